// file: common/ssp_pkg.sv
// package for the spindle speed pwm controller
package ssp_pkg;
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned SENSE_SYNC   = 2;
  localparam int unsigned STEPS        = 8;
  localparam int unsigned STEP_W       = 3;
  localparam logic [2:0]  STEP_MIN     = 3'h0;
  localparam logic [2:0]  STEP_MAX     = 3'h7;
  localparam int unsigned REF_DIV      = 100;
  localparam int unsigned PWM_SLOT     = 16;
  localparam int unsigned CNT_W        = 24;
  localparam int unsigned TARGET_REFS  = 10000;
  localparam int unsigned ERR_SHIFT    = 4;
  localparam logic        PHASE_RESET  = 1'b0;

  typedef enum logic [1:0] {
    SSP_IDLE  = 2'b00,
    SSP_START = 2'b01,
    SSP_RUN   = 2'b10
  } ssp_state_t;

  typedef struct packed {
    logic       drive_pwm;
    logic       phase_a;
    logic       phase_b;
    logic       at_speed;
  } ssp_drive_t;
endpackage

// file: logic/ssp_pwm_gen.sv
// eight-step duty cycle pulse generator
`timescale 1ns/100ps
`default_nettype none
module ssp_pwm_gen
  import ssp_pkg::*;
#(
  parameter int unsigned SLOT = PWM_SLOT
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              tick,
  input  wire logic [STEP_W-1:0] step,
  input  wire logic              full,
  output logic                   pwm
);
  localparam int unsigned PER = (STEPS - 1) * SLOT;
  localparam int unsigned PW  = $clog2(PER + 1);
  initial begin
    if (SLOT < 1) $error("ssp_pwm_gen: slot must be at least one");
  end

  logic [PW-1:0] pos_r;
  logic [PW-1:0] pos_nxt;
  wire  [PW-1:0] width;
  wire           pwm_nxt;

  // step 0 is 0 %, step 7 covers the whole period (100 %)
  assign width   = PW'(step * SLOT);
  assign pos_nxt = (pos_r == PW'(PER - 1)) ? '0 : pos_r + PW'(1);
  assign pwm_nxt = full | (pos_r < width);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pos_r <= '0;
      pwm   <= 1'b0;
    end else if (tick) begin
      pos_r <= pos_nxt;
      pwm   <= pwm_nxt;
    end
  end
endmodule
`default_nettype wire

// file: logic/ssp_speed_ctl.sv
// spindle speed controller: speed measurement, pwm drive, commutation
// Functional notes
// - measure spindle period in reference clock ticks derived from the processor clock
// - drive pulse width grows with how far speed falls below target
// - duty cycle has eight steps, zero to one hundred percent
// - during start-up the drive is held at full duty
// - commutation advances once per phase on each sensor edge
`timescale 1ns/100ps
`default_nettype none
module ssp_speed_ctl
  import ssp_pkg::*;
#(
  parameter int unsigned DIV    = REF_DIV,
  parameter int unsigned TARGET = TARGET_REFS,
  parameter int unsigned SHIFT  = ERR_SHIFT
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  input  wire logic   motor_on,
  input  wire logic   sensor,
  output ssp_drive_t  drive
);
  initial begin
    if (DIV < 2) $error("ssp_speed_ctl: divider must be at least two");
    if (TARGET < 2 || TARGET >= (1 << (CNT_W - 1)))
      $error("ssp_speed_ctl: target out of range");
    if (SHIFT >= CNT_W)
      $error("ssp_speed_ctl: shift must stay below the counter width");
    if (STEPS != (1 << STEP_W))
      $error("ssp_speed_ctl: step count does not match step width");
    if (SENSE_SYNC < 2)
      $error("ssp_speed_ctl: sensor needs at least two synchroniser stages");
  end

  localparam int unsigned      DW  = $clog2(DIV);
  localparam logic [CNT_W-1:0] TGT = CNT_W'(TARGET);

  logic [DW-1:0]    div_r;
  logic             ref_r;
  logic [SENSE_SYNC-1:0] sync_r;
  logic             sens_d_r;
  logic [CNT_W-1:0] per_cnt_r;
  logic [CNT_W-1:0] per_r;
  logic             per_ok_r;
  logic             ph_r;
  logic [STEP_W-1:0] step_r;
  logic             at_speed_r;
  ssp_state_t       state_r;
  ssp_state_t       state_nxt;
  logic             pwm;

  wire              sens_edge;
  wire [CNT_W-1:0]  per_cnt_nxt;
  wire [CNT_W-1:0]  err;
  wire [CNT_W-1:0]  err_q;
  wire [STEP_W-1:0] step_nxt;
  wire              full;
  wire              div_wrap;
  wire              at_target;
  wire              in_run;
  wire              ph_nxt;
  wire              drive_en;
  wire ssp_drive_t  drive_nxt;

  // reference tick from the processor clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_r <= '0;
      ref_r <= 1'b0;
    end else begin
      div_r <= div_wrap ? '0 : div_r + DW'(1);
      ref_r <= div_wrap;
    end
  end
  assign div_wrap = (div_r == DW'(DIV - 1));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_r   <= '0;
      sens_d_r <= 1'b0;
    end else begin
      sync_r[0] <= sensor;
      for (int i = 1; i < SENSE_SYNC; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
      sens_d_r <= sync_r[SENSE_SYNC-1];
    end
  end
  assign sens_edge = sync_r[SENSE_SYNC-1] ^ sens_d_r;

  // period count saturates so a stalled motor reads as slowest
  assign per_cnt_nxt = (per_cnt_r == '1) ? per_cnt_r : per_cnt_r + CNT_W'(1);

  // motor off clears the measurement and parks per_r at all ones, which reads as slowest
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !motor_on) begin
      per_cnt_r <= '0;
      per_r     <= '1;
      per_ok_r  <= 1'b0;
    end else if (sens_edge) begin
      per_r     <= per_cnt_r;
      per_cnt_r <= '0;
      per_ok_r  <= 1'b1;
    end else if (ref_r) begin
      per_cnt_r <= per_cnt_nxt;
      if (per_cnt_nxt > per_r) begin
        per_r <= per_cnt_nxt;
      end
    end
  end

  // longer period than target means too slow
  assign err       = (per_r > TGT) ? per_r - TGT : '0;
  assign err_q     = err >> SHIFT;

  // shared decodes
  assign at_target = (err == '0);
  assign in_run    = (state_r == SSP_RUN);

  // clamp the scaled error onto the duty steps
  function automatic logic [STEP_W-1:0] to_step(input logic [CNT_W-1:0] e);
    logic [STEP_W-1:0] s;
    s = STEP_MIN;
    if (e > CNT_W'(STEP_MAX)) begin
      s = STEP_MAX;
    end else begin
      s = e[STEP_W-1:0];
    end
    return s;
  endfunction

  assign step_nxt = at_target ? STEP_MIN : to_step(err_q);

  // full drive holds until one measured period lands at or under target
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SSP_IDLE: begin
        if (motor_on)
          state_nxt = SSP_START;
      end
      SSP_START: begin
        if (!motor_on)
          state_nxt = SSP_IDLE;
        else if (per_ok_r && at_target)
          state_nxt = SSP_RUN;
      end
      SSP_RUN: begin
        if (!motor_on)
          state_nxt = SSP_IDLE;
      end
      default: begin
        state_nxt = SSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= SSP_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // step and at-speed follow the measurement only once running
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      step_r     <= STEP_MIN;
      at_speed_r <= 1'b0;
    end else begin
      step_r     <= in_run ? step_nxt : STEP_MIN;
      at_speed_r <= in_run && at_target;
    end
  end

  // phase parks while the motor is off so every start begins on phase a
  assign ph_nxt = !motor_on ? PHASE_RESET :
                  sens_edge ? ~ph_r       :
                  ph_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ph_r <= PHASE_RESET;
    end else begin
      ph_r <= ph_nxt;
    end
  end

  assign full = (state_r == SSP_START);

  ssp_pwm_gen #(
    .SLOT (PWM_SLOT)
  ) u_pwm (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (ref_r),
    .step    (step_r),
    .full    (full),
    .pwm     (pwm)
  );

  // pwm level feeds the external filter and current amplifier
  assign drive_en  = motor_on;
  assign drive_nxt = '{
    drive_pwm: pwm & drive_en,
    phase_a:   drive_en & ~ph_r,
    phase_b:   drive_en & ph_r,
    at_speed:  at_speed_r
  };

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive <= '0;
    end else begin
      drive <= drive_nxt;
    end
  end
endmodule
`default_nettype wire

// file: tb/ssp_motor.sv
// motor model: phase sensor and filtered amplifier current
`timescale 1ns/100ps
`default_nettype none
module ssp_motor (
  input  wire logic       sys_clk,
  input  wire logic       drive_pwm,
  input  wire logic [7:0] half,
  output logic            sensor = 1'b0,
  output logic [7:0]      amps = 8'h0
);
  logic [7:0] cnt_r = 8'h0;
  wire logic  flip = half != 8'h0 && cnt_r + 8'h1 >= half;
  // sensor stands still while half is zero, else flips once per phase
  always @(posedge sys_clk) begin
    cnt_r <= (flip || half == 8'h0) ? 8'h0 : cnt_r + 8'h1;
    sensor <= sensor ^ flip;
    amps <= amps - (amps >> 3) + (drive_pwm ? 8'h1f : 8'h0);
  end
endmodule
`default_nettype wire

// file: tb/ssp_speed_ctl_checker.sv
// assertion checker for the spindle speed controller
`timescale 1ns/100ps
`default_nettype none
module ssp_chk
  import ssp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       motor_on,
  input wire logic       sensor,
  input wire ssp_drive_t drive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last sensor edge, saturating
  logic [9:0] still_r;
  always_ff @(posedge sys_clk) begin
    still_r <= (!rst_n || sensor != $past(sensor)) ? 10'h0 : still_r + {9'h0, ~&still_r};
  end
  sequence s_on; motor_on[*4]; endsequence
  AST_START: assert property ($rose(motor_on) |-> ##4 drive.drive_pwm[*4])
    else $error("drive not full at start");
  AST_PH_HOT: assert property (s_on |-> drive.phase_a ^ drive.phase_b)
    else $error("phases not one-hot");
  AST_PH_STEP: assert property (motor_on && $changed(sensor) |->
    ##[2:8] $changed({drive.phase_a, drive.phase_b})) else $error("phase did not advance");
  AST_ZERO: assert property (drive.at_speed[*8] |-> ##[0:250] !drive.drive_pwm)
    else $error("drive stuck high at speed");
  AST_STALL: assert property (s_on ##0 &still_r |-> drive.drive_pwm)
    else $error("stalled motor not at full duty");
  AST_SLOW: assert property (s_on ##0 &still_r |-> !drive.at_speed)
    else $error("stalled motor reported at speed");
  AST_OFF: assert property (!motor_on |=> !drive.drive_pwm && !drive.phase_a && !drive.phase_b)
    else $error("drive active while motor off");
endmodule
bind ssp_speed_ctl ssp_chk ssp_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .motor_on(motor_on), .sensor(sensor), .drive(drive));
`default_nettype wire

// file: tb/tb_top.sv
// testbench for the spindle speed controller
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ssp_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       motor_on = 1'b0;
  logic [7:0] half = 8'h0;
  logic       sensor;
  logic [7:0] amps;
  ssp_drive_t drive;
  int         failures = 0;
  int         samples_checked = 0;
  int         hi;
  initial forever #5 sys_clk = ~sys_clk;
  ssp_speed_ctl #(.DIV(2), .TARGET(20), .SHIFT(0)) ssp_speed_ctl_inst (.sys_clk(sys_clk),
    .rst_n(rst_n), .motor_on(motor_on), .sensor(sensor), .drive(drive));
  ssp_motor ssp_motor_inst (.sys_clk(sys_clk), .drive_pwm(drive.drive_pwm), .half(half),
    .sensor(sensor), .amps(amps));
  task chk(input int got, input int lo, input int top);
    samples_checked++;
    if (got < lo || got > top) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, top);
    end
  endtask
  // settle, then count drive high cycles over two pwm periods
  task go(input int n, input logic on, input logic [7:0] h);
    motor_on <= on;
    half <= h;
    repeat (n) @(posedge sys_clk);
    hi = 0;
    repeat (448) begin
      @(negedge sys_clk);
      hi += int'(drive.drive_pwm === 1'b1);
    end
    @(posedge sys_clk);
  endtask
  task t_start;
    go(5, 1'b1, 8'h0);
    chk(hi, 448, 448);
  endtask
  task t_fast;
    go(800, 1'b1, 8'h1e);
    chk(hi, 0, 0);
    chk(int'(drive.at_speed === 1'b1), 1, 1);
  endtask
  task t_mid;
    go(900, 1'b1, 8'h2e);
    chk(hi, 128, 256);
  endtask
  task t_stall;
    go(1500, 1'b1, 8'h0);
    chk(hi, 448, 448);
    chk(int'(amps > 8'hc8), 1, 1);
  endtask
  task t_off;
    go(4, 1'b0, 8'h1e);
    chk(int'(drive === 4'h0), 1, 1);
    chk(hi, 0, 0);
  endtask
  task end_sim;
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_start();
    t_fast();
    t_mid();
    t_stall();
    t_off();
    end_sim();
  end
endmodule
`default_nettype wire
